// [verilog/sdfl_top.sv]
// Purpose: serial frame loader for an 8-bit voltage-output converter
// Assumes: CLK_I at 200 MHz oversamples the three serial pins
// Notes:   the converter core takes a code when UPDATE_READY_I is high
//
// Behaviour
// - after the frame strobe falls, each of the first sixteen falling serial clock edges shifts the data pin into a 16-bit shift register.
// - the shift register is enabled only while the strobe is low, and serial clock activity with the strobe high is ignored.
// - on the sixteenth serial clock of a frame the received word is passed on to update the converter code.
// - a strobe rising edge before the sixteenth clock aborts the frame and the partial word is dropped, code unchanged.
// - after reset the code is held at zero until the first complete frame has been taken.
// - the converter code is an 8-bit unsigned value that sets the output voltage.
`include "sdfl_map.svh"

module sdfl_top (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic SCLK_I,
  input wire logic SYNC_N_I,
  input wire logic DIN_I,
  input wire logic UPDATE_READY_I,
  output logic [7:0] ANALOG_OUTPUT_O,
  output logic [1:0] POWER_MODE_O,
  output logic LOADED_O,
  output logic FRAME_ABORT_O,
  output logic RATE_ERR_O,
  output logic BUSY_O
);

  sdfl_pkg::sdfl_pins_t pins_raw;
  sdfl_pkg::sdfl_pins_t pins_f;
  sdfl_pkg::sdfl_pins_t pins_prev_q;
  sdfl_pkg::sdfl_state_t state_q;
  sdfl_pkg::sdfl_state_t state_d;
  sdfl_pkg::sdfl_word_t pend_word_q;
  sdfl_pkg::sdfl_word_t fifo_out;
  logic [`SDFL_WORD_BITS-1:0] sh_q;
  logic [`SDFL_WORD_BITS-1:0] sh_d;
  logic [`SDFL_CNT_W-1:0] cnt_q;
  logic [`SDFL_CNT_W-1:0] cnt_d;
  logic [`SDFL_GAP_W-1:0] gap_q;
  logic pend_q;
  logic pend_d;
  logic abort_q;
  logic rate_err_q;
  logic [7:0] code_q;
  logic [1:0] mode_q;
  logic loaded_q;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  logic frame_start;
  logic bit_take;
  logic last_bit;
  logic frame_abort;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic pop;
  logic gap_short;

  // all three pins share one synchroniser, so their skew is preserved
  assign pins_raw = '{sclk: SCLK_I, sync_n: SYNC_N_I, din: DIN_I};

  // reset levels are the idle pins: clock high, strobe high, data low
  sdfl_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h6)
  ) u_sync (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .async_i(pins_raw),
    .filt_o(pins_f)
  );

  // previous filtered levels for edge detection
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pins_prev_q <= 3'h6; // idle levels, so no false edge follows reset
    end else begin
      pins_prev_q <= pins_f;
    end
  end

  // edge events on the filtered pins
  assign sclk_fall = pins_prev_q.sclk & ~pins_f.sclk;
  assign sync_fall = pins_prev_q.sync_n & ~pins_f.sync_n;
  assign sync_rise = ~pins_prev_q.sync_n & pins_f.sync_n;

  // one helper for the state tests of frame_start, bit_take and frame_abort, so the decodes cannot drift apart
  function automatic logic in_state(input sdfl_pkg::sdfl_state_t s,
                                    input sdfl_pkg::sdfl_state_t want);
    in_state = (s == want);
  endfunction

  // a new frame is refused while a finished word still waits,
  // which is how a full buffer stalls the serial side
  assign frame_start = in_state(state_q, sdfl_pkg::SDFL_IDLE) & sync_fall
                       & ~pend_q;
  // strobe low plus shifting state gate every bit
  assign bit_take = in_state(state_q, sdfl_pkg::SDFL_SHIFT) & sclk_fall
                    & ~pins_f.sync_n;
  assign last_bit = bit_take & (cnt_q == `SDFL_CNT_LAST);
  assign frame_abort = in_state(state_q, sdfl_pkg::SDFL_SHIFT)
                       & sync_rise;

  // shift register and bit count of the running frame
  assign sh_d = bit_take ? {sh_q[`SDFL_WORD_BITS-2:0], pins_f.din}
                         : sh_q;
  assign cnt_d = frame_start ? '0
               : bit_take ? cnt_q + 1'b1 : cnt_q;

  // frame sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      sdfl_pkg::SDFL_IDLE: begin
        if (frame_start) state_d = sdfl_pkg::SDFL_SHIFT;
      end
      sdfl_pkg::SDFL_SHIFT: begin
        if (frame_abort) begin
          state_d = sdfl_pkg::SDFL_IDLE;
        end else if (last_bit) begin
          state_d = sdfl_pkg::SDFL_DONE;
        end
      end
      sdfl_pkg::SDFL_DONE: begin
        // clocks beyond the sixteenth are ignored until the strobe rises
        if (sync_rise) state_d = sdfl_pkg::SDFL_IDLE;
      end
      default: state_d = sdfl_pkg::SDFL_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_q <= sdfl_pkg::SDFL_IDLE;
      sh_q <= `SDFL_WORD_RESET;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
    end
  end

  // finished word waits here until the buffer takes it;
  // a set in the same cycle as the hand-off wins
  assign pend_d = last_bit | (pend_q & ~fifo_in_ready);

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pend_q <= 1'b0;
      pend_word_q <= '0;
    end else begin
      pend_q <= pend_d;
      if (last_bit) begin
        // field split of the most-significant-first word
        pend_word_q.mode <= sh_d[`SDFL_MODE_MSB:`SDFL_MODE_LSB];
        pend_word_q.code <= sh_d[`SDFL_CODE_MSB:`SDFL_CODE_LSB];
      end
    end
  end

  sdfl_fifo #(
    .WIDTH($bits(sdfl_pkg::sdfl_word_t)),
    .DEPTH(`SDFL_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .in_valid_i(pend_q),
    .in_ready_o(fifo_in_ready),
    .in_data_i(pend_word_q),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(UPDATE_READY_I),
    .out_data_o(fifo_out)
  );

  assign pop = fifo_out_valid & UPDATE_READY_I;

  // converter code: zero from reset until the first word arrives
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      code_q <= `SDFL_CODE_RESET;
      mode_q <= `SDFL_MODE_RESET;
      loaded_q <= 1'b0;
    end else if (pop) begin
      code_q <= fifo_out.code;
      mode_q <= fifo_out.mode;
      loaded_q <= 1'b1;
    end
  end

  // serial clock rate watch: spacing of in-frame falls, with one
  // cycle of slack because sampling jitters the measured period
  assign gap_short = bit_take & (cnt_q != '0)
                     & (gap_q < `SDFL_GAP_W'(`SDFL_SCLK_MIN_CYC - 1));

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      gap_q <= '0;
      rate_err_q <= 1'b0;
    end else begin
      if (bit_take) begin
        gap_q <= `SDFL_GAP_W'(1);
      end else if (gap_q != '1) begin
        gap_q <= gap_q + 1'b1;
      end
      if (frame_start) begin
        rate_err_q <= 1'b0;
      end else if (gap_short) begin
        rate_err_q <= 1'b1;
      end
    end
  end

  // one-cycle abort pulse, registered
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= frame_abort;
    end
  end

  assign ANALOG_OUTPUT_O = code_q;
  assign POWER_MODE_O = mode_q;
  assign LOADED_O = loaded_q;
  assign FRAME_ABORT_O = abort_q;
  assign RATE_ERR_O = rate_err_q;
  assign BUSY_O = pend_q | fifo_out_valid;

  // checks on the frame logic
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  a_bit_capture: assert property (
    bit_take |=> sh_q[0] == $past(pins_f.din)
                 && sh_q[15:1] == $past(sh_q[14:0]))
    else $error("data bit not shifted in on serial clock fall");

  a_idle_ignores: assert property (
    (state_q != sdfl_pkg::SDFL_SHIFT) |=> $stable(sh_q))
    else $error("shift register moved outside a frame");

  a_sixteenth_load: assert property (
    last_bit && !frame_abort |=> pend_q
      && state_q == sdfl_pkg::SDFL_DONE
      && pend_word_q.code == $past(sh_d[13:6]))
    else $error("sixteenth clock did not load the word");

  a_count_bits: assert property (
    frame_start ##1 (!bit_take && !frame_abort) [*8]
      |-> cnt_q == 4'h0 && state_q == sdfl_pkg::SDFL_SHIFT)
    else $error("bit count moved without a clock");

  a_abort_drop: assert property (
    frame_abort |=> state_q == sdfl_pkg::SDFL_IDLE
      && FRAME_ABORT_O && !pend_q)
    else $error("aborted frame was not dropped");

  a_code_zero: assert property (
    !loaded_q |-> ANALOG_OUTPUT_O == 8'h00)
    else $error("code not zero before first write");

  a_code_hold: assert property (
    !pop |=> $stable(code_q) && $stable(mode_q))
    else $error("code changed without a buffered word");

  a_field_split: assert property (
    pop |=> ANALOG_OUTPUT_O == $past(fifo_out.code)
      && POWER_MODE_O == $past(fifo_out.mode) && LOADED_O)
    else $error("word fields not applied to the outputs");

  a_strobe_gate: assert property (
    sclk_fall && pins_f.sync_n |=> $stable(sh_q) && $stable(cnt_q))
    else $error("serial clock moved the shift register with strobe high");

  a_done_ignores: assert property (
    state_q == sdfl_pkg::SDFL_DONE && !sync_rise
      |=> state_q == sdfl_pkg::SDFL_DONE && $stable(sh_q)
      && $stable(cnt_q))
    else $error("clock after the sixteenth changed the frame");

  a_word_waits: assert property (
    pend_q && !fifo_in_ready |=> pend_q && $stable(pend_word_q))
    else $error("waiting word lost while the buffer was full");

  a_stall_refuse: assert property (
    state_q == sdfl_pkg::SDFL_IDLE && sync_fall && pend_q
      |=> state_q == sdfl_pkg::SDFL_IDLE)
    else $error("frame started while a word still waited");

  a_abort_pulse: assert property (
    FRAME_ABORT_O |=> !FRAME_ABORT_O)
    else $error("abort pulse longer than one cycle");

  a_loaded_sticky: assert property (
    LOADED_O |=> LOADED_O)
    else $error("loaded flag fell without a reset");

  a_rate_flag: assert property (
    gap_short |=> RATE_ERR_O)
    else $error("fast serial clock was not flagged");

  a_rate_clear: assert property (
    frame_start |=> !RATE_ERR_O)
    else $error("rate flag not cleared at frame start");

endmodule

// [verilog/sdfl_map.svh]
// Purpose: constants of the serial frame loader
// Assumes: included by bare name, definitions only
// Notes:   frame layout is sent most significant bit first
`ifndef SDFL_MAP_SVH
`define SDFL_MAP_SVH

// frame geometry
`define SDFL_WORD_BITS 16
`define SDFL_CNT_W 4
`define SDFL_CNT_LAST 4'hf
`define SDFL_MODE_MSB 15
`define SDFL_MODE_LSB 14
`define SDFL_CODE_MSB 13
`define SDFL_CODE_LSB 6

// reset values
`define SDFL_CODE_RESET 8'h00
`define SDFL_MODE_RESET 2'h0
`define SDFL_WORD_RESET 16'h0000

// buffering
`define SDFL_FIFO_DEPTH 4

// timing: serial clock limit and local clock, both as periods
`define SDFL_SCLK_MAX_MHZ 30
`define SDFL_SCLK_MIN_PS (1000000 / `SDFL_SCLK_MAX_MHZ)
`define SDFL_CLK_PS 5000
`define SDFL_SCLK_MIN_CYC \
  ((`SDFL_SCLK_MIN_PS + `SDFL_CLK_PS - 1) / `SDFL_CLK_PS)
`define SDFL_GAP_W 4
`endif

// [verilog/sdfl_pkg.sv]
// Purpose: shared types of the serial frame loader
// Assumes: nothing is imported, users write sdfl_pkg::name
// Notes:   state codes are one-hot
package sdfl_pkg;

  // one decoded frame as it travels through the buffer
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] code;
  } sdfl_word_t;

  // the three serial pins as one group
  typedef struct packed {
    logic sclk;
    logic sync_n;
    logic din;
  } sdfl_pins_t;

  typedef enum logic [2:0] {
    SDFL_IDLE  = 3'b001,
    SDFL_SHIFT = 3'b010,
    SDFL_DONE  = 3'b100
  } sdfl_state_t;

endpackage

// [verilog/sdfl_sync.sv]
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to CLK_I
// Notes:   output moves only when stages two and three agree
module sdfl_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] filt_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] filt_d;

  // per bit: take the new level only once it is seen twice in a row
  assign agree = ~(s2_q ^ s3_q);
  assign filt_d = (agree & s3_q) | (~agree & filt_o);

  // s1_q feeds only s2_q, so metastability never reaches a gate
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      filt_o <= RESET_VAL;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_o <= filt_d;
    end
  end

endmodule

// [verilog/sdfl_fifo.sv]
// Purpose: small first-in first-out buffer with valid and ready
// Assumes: single clock, push and pop may share a cycle
// Notes:   read data comes straight from the storage flops
module sdfl_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // honest flags: full stalls the writer, empty hides the data
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_q[rd_q];

  // pointer wrap works for any depth, not only powers of two
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // storage has no reset: it is never read while empty
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= next_ptr(wr_q);
      if (pop) rd_q <= next_ptr(rd_q);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// [dv/sdfl_host_model.sv]
// Purpose: host serial master that loads frames into the loader
// Assumes: link clock of 125 ns, idle high, still between frames
// Notes:   data lines show the inverse of the last bit once released
module sdfl_host_model (
  output sdfl_pkg::sdfl_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // half of the 8 MHz link period, well under the 30 MHz limit
  localparam realtime HALF = 62.5;
  // 25 ns period, beyond the limit on purpose to trip the rate watch
  localparam realtime FAST = 12.5;

  initial begin
    pins_o = '{sclk: 1'b1, sync_n: 1'b1, din: 1'b0};
  end

  // one frame; more than 16 bits repeats the word, fewer aborts it
  task automatic send(input logic [15:0] word, input int nbits);
    #0.3;
    pins_o.sync_n = 1'b0;
    #(HALF);
    for (int i = 0; i < nbits; i++) begin
      pins_o.din = word[15 - (i % 16)];
      #(HALF);
      pins_o.sclk = 1'b0;
      #(HALF);
      pins_o.sclk = 1'b1;
    end
    pins_o.sync_n = 1'b1;
    pins_o.din = ~pins_o.din;
    #(2 * HALF);
  endtask

  // one full frame at the fast rate; only the rate watch test uses it
  task automatic send_fast(input logic [15:0] word);
    #0.3;
    pins_o.sync_n = 1'b0;
    #(HALF);
    for (int i = 0; i < 16; i++) begin
      pins_o.din = word[15 - i];
      #(FAST);
      pins_o.sclk = 1'b0;
      #(FAST);
      pins_o.sclk = 1'b1;
    end
    pins_o.sync_n = 1'b1;
    pins_o.din = ~pins_o.din;
    #(2 * HALF);
  endtask

  // clock activity with the strobe high must be ignored
  task automatic idle_clocks(input int n);
    repeat (n) begin
      pins_o.din = ~pins_o.din;
      pins_o.sclk = 1'b0;
      #(HALF);
      pins_o.sclk = 1'b1;
      #(HALF);
    end
  endtask
endmodule

// [dv/serial_dac_frame_loader_test.sv]
// Purpose: self-checking bench for the serial frame loader
// Assumes: host model drives the pins, bench drives reset and ready
// Notes:   table rows first, then stall, drain and mid-run reset
module serial_dac_frame_loader_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [15:0] word;
    int nbits;
    logic [7:0] code;
    logic [1:0] mode;
  } sdfl_row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ready = 1'b1;
  sdfl_pkg::sdfl_pins_t pins;
  logic [7:0] code;
  logic [1:0] mode;
  logic loaded;
  logic abort;
  logic rate_err;
  logic busy;
  logic [7:0] last;
  logic [7:0] seen [$];
  int fails = 0;
  int num_checks = 0;
  int aborts = 0;
  int ab;
  // 15 bits aborts and keeps the code, 18 bits ignores the extra two
  sdfl_row_t rows [6] = '{
    '{16'hffc0, 16, 8'hff, 2'h3}, '{16'h0000, 16, 8'h00, 2'h0},
    '{16'h4aa5, 16, 8'h2a, 2'h1}, '{16'h8055, 16, 8'h01, 2'h2},
    '{16'hffff, 15, 8'h01, 2'h2}, '{16'h3fc0, 18, 8'hff, 2'h0}};

  sdfl_host_model host (.pins_o(pins));

  sdfl_top dut (
    .CLK_I(clk), .ARST_N_I(arst_n), .SCLK_I(pins.sclk),
    .SYNC_N_I(pins.sync_n), .DIN_I(pins.din), .UPDATE_READY_I(ready),
    .ANALOG_OUTPUT_O(code), .POWER_MODE_O(mode), .LOADED_O(loaded),
    .FRAME_ABORT_O(abort), .RATE_ERR_O(rate_err), .BUSY_O(busy));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // abort is a one-cycle pulse; counting at the falling edge reads it
  // settled, away from the edge that launches it
  always @(negedge clk) begin
    if (abort === 1'b1) aborts++;
  end

  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // whole run is about 30 us of frames; a hang stops well after
  initial begin
    #300us;
    fails++;
    wrap_up();
  end

  initial begin
    repeat (4) @(negedge clk);
    chk(code === 8'h00 && loaded === 1'b0, "code in reset");
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    host.idle_clocks(4);
    @(negedge clk);
    chk(code === 8'h00 && loaded === 1'b0, "idle clocks");
    // ordinary frames, short and long ones included
    foreach (rows[i]) begin
      ab = aborts;
      host.send(rows[i].word, rows[i].nbits);
      @(negedge clk);
      chk(code === rows[i].code, "code");
      chk(mode === rows[i].mode, "mode");
      chk(aborts == ab + int'(rows[i].nbits < 16), "abort");
      chk(loaded === 1'b1 && rate_err === 1'b0, "flags");
    end
    // stall the converter: four queue, one pends, the sixth is refused
    ready = 1'b0;
    for (int k = 0; k < 6; k++) begin
      host.send({2'b00, 8'(8'h10 + k), 6'h00}, 16);
    end
    @(negedge clk);
    chk(busy === 1'b1 && code === 8'hff, "stalled");
    ready = 1'b1;
    last = 8'hff;
    repeat (12) begin
      @(negedge clk);
      if (code !== last) seen.push_back(code);
      last = code;
    end
    chk(seen.size() == 5, "pop count");
    foreach (seen[k]) begin
      chk(seen[k] === 8'(8'h10 + k), "pop order");
    end
    chk(busy === 1'b0, "drained");
    // a link clock above the limit still loads, but raises the flag
    host.send_fast(16'h4d40);
    @(negedge clk);
    chk(rate_err === 1'b1 && code === 8'h35, "rate flag");
    chk(mode === 2'h1 && abort === 1'b0, "fast frame mode");
    // second reset in mid-run, then the first write after it
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(code === 8'h00 && loaded === 1'b0, "mid reset");
    chk(mode === 2'h0 && busy === 1'b0 && rate_err === 1'b0,
        "mid reset flags");
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    host.send(16'h0040, 16);
    @(negedge clk);
    chk(code === 8'h01 && loaded === 1'b1, "after reset");
    wrap_up();
  end
endmodule
